// [src/tcoc_compare_output.v]
/*
 Compare-output control for a 16-bit timer: the first control register,
 the two waveform output units, the match flags and buffered compare load.
 Assumes the counter, its direction, TOP and the upper mode bits come from
 the counter unit; tick is a clock enable on the I/O clock.
*/
`include "tcoc_regs.vh"
`default_nettype none
// What this block does
// - Synchronous to I/O clock, tick is enable
// - Phase-frequency mode loads compare at BOTTOM
// - Control register at 0x2F, reset zero
// - Also reachable at data address 0x4F
// - Nonzero output mode takes over the pin, except toggle in PWM modes without toggle
// - Non-PWM: off, toggle, clear, set on match
// - Fast PWM: clear/set on match, opposite BOTTOM
// - Fast PWM toggle only channel A, mode 15
// - Fast PWM compare at TOP acts at BOTTOM
// - Dual slope: up/down match set or clear
// - Dual slope toggle only A, mode 9
// - Force strobes act only in non-PWM modes
// - Force strobe applies immediate match, self-clears
// - Forced match sets no flag, no clear
// - Force strobe bits read as zero
// - Four-bit mode decoded into mode classes
module tcoc_compare_output (
    input wire clock,
    input wire rst_b,
    input wire clk_en,
    input wire timer_tick_enable,
    input wire [5:0] io_addr,
    input wire io_rd,
    input wire io_wr,
    input wire [7:0] data_addr,
    input wire data_rd,
    input wire data_wr,
    input wire [7:0] wdata,
    input wire [1:0] waveform_mode_upper,
    input wire [15:0] counter_value,
    input wire [15:0] counter_top,
    input wire count_down,
    input wire [15:0] chan_a_compare_buffer,
    input wire [15:0] chan_b_compare_buffer,
    input wire flag_clear_a,
    input wire flag_clear_b,
    output reg [7:0] rdata,
    output reg [3:0] waveform_mode_select,
    output reg [15:0] chan_a_compare_value,
    output reg [15:0] chan_b_compare_value,
    output reg chan_a_compare_pin,
    output reg chan_b_compare_pin,
    output reg chan_a_pin_override,
    output reg chan_b_pin_override,
    output reg chan_a_compare_match_flag,
    output reg chan_b_compare_match_flag,
    output reg match_clear_counter
);

// ****************************************************************
// Register access
// ****************************************************************
reg [5:0] timer_output_mode_control;
wire io_hit;
wire data_hit;
wire reg_wr;
wire reg_rd;
wire [3:0] next_mode;
wire [7:0] read_value;
assign io_hit = (io_addr == `TCOC_IO_OFFSET);
assign data_hit = (data_addr == `TCOC_DATA_OFFSET);
assign reg_wr = (io_hit && io_wr) || (data_hit && data_wr);
assign reg_rd = (io_hit && io_rd) || (data_hit && data_rd);
assign read_value = {timer_output_mode_control[5:2], 2'h0,
    timer_output_mode_control[1:0]};
assign next_mode = reg_wr ?
    {waveform_mode_upper, wdata[`TCOC_WGM_HI:`TCOC_WGM_LO]} :
    {waveform_mode_upper, timer_output_mode_control[1:0]};

// ****************************************************************
// Mode decode
// ****************************************************************
wire [3:0] wgm;
wire is_fast;
wire is_dual;
wire is_pfc;
wire is_nonpwm;
assign wgm = next_mode;
assign is_fast = (wgm == 4'h5) || (wgm == 4'h6) || (wgm == 4'h7) ||
    (wgm == `TCOC_WGM_FAST_ICR) || (wgm == `TCOC_WGM_FAST_OCR);
assign is_pfc = (wgm == 4'h8) || (wgm == `TCOC_WGM_PFC_OCR);
assign is_dual = is_pfc || (wgm == 4'h1) || (wgm == 4'h2) ||
    (wgm == 4'h3) || (wgm == `TCOC_WGM_PC_ICR) || (wgm == 4'hB);
assign is_nonpwm = !is_fast && !is_dual &&
    (wgm != `TCOC_WGM_RESERVED);

// ****************************************************************
// Output units, one per channel
// ****************************************************************
wire [1:0] mode_of [0:1];
wire [1:0] force_wr;
wire [15:0] cmp_of [0:1];
wire [1:0] match_eq;
wire [1:0] pin_now;
wire [1:0] next_pin;
wire at_bottom;
wire at_top;
wire load_now;
assign mode_of[0] = reg_wr ? wdata[`TCOC_A_MODE_HI:`TCOC_A_MODE_LO] :
    timer_output_mode_control[5:4];
assign mode_of[1] = reg_wr ? wdata[`TCOC_B_MODE_HI:`TCOC_B_MODE_LO] :
    timer_output_mode_control[3:2];
assign force_wr[0] = reg_wr && wdata[`TCOC_A_FORCE_BIT];
assign force_wr[1] = reg_wr && wdata[`TCOC_B_FORCE_BIT];
assign cmp_of[0] = chan_a_compare_value;
assign cmp_of[1] = chan_b_compare_value;
assign pin_now[0] = chan_a_compare_pin;
assign pin_now[1] = chan_b_compare_pin;
assign at_bottom = (counter_value == `TCOC_BOTTOM);
assign at_top = (counter_value == counter_top);
assign load_now = is_pfc ? at_bottom :
    (is_fast ? at_bottom : (is_dual ? at_top : 1'b1));

genvar ch;
generate
    for (ch = 0; ch < 2; ch = ch + 1)
    begin : g_unit
        reg np;
        wire toggle_ok;
        assign match_eq[ch] = (counter_value == cmp_of[ch]);
        assign toggle_ok = (ch == 0) && (is_fast ?
            (wgm == `TCOC_WGM_FAST_OCR) :
            ((wgm == `TCOC_WGM_PFC_OCR) ||
            (wgm == `TCOC_WGM_FAST_ICR)));
        always @*
        begin
            np = pin_now[ch];
            if (is_nonpwm)
            begin
                if ((timer_tick_enable && match_eq[ch]) || force_wr[ch])
                begin
                    case (mode_of[ch])
                        `TCOC_OM_TOGGLE: np = !pin_now[ch];
                        `TCOC_OM_CLEAR: np = 1'b0;
                        `TCOC_OM_SET: np = 1'b1;
                        default: np = pin_now[ch];
                    endcase
                end
            end
            else if (timer_tick_enable && is_fast)
            begin
                if (mode_of[ch][1])
                begin
                    if (at_bottom)
                        np = !mode_of[ch][0];
                    else if (match_eq[ch] && (cmp_of[ch] != counter_top))
                        np = mode_of[ch][0];
                end
                else if (mode_of[ch][0] && toggle_ok && match_eq[ch])
                    np = !pin_now[ch];
            end
            else if (timer_tick_enable && is_dual && match_eq[ch])
            begin
                if (mode_of[ch][1])
                    np = mode_of[ch][0] ^ count_down;
                else if (mode_of[ch][0] && toggle_ok)
                    np = !pin_now[ch];
            end
        end
        assign next_pin[ch] = np;
    end
endgenerate

wire [1:0] override;
wire a_toggle_ok;
assign a_toggle_ok = is_fast ? (wgm == `TCOC_WGM_FAST_OCR) :
    (is_dual && ((wgm == `TCOC_WGM_PFC_OCR) ||
    (wgm == `TCOC_WGM_FAST_ICR)));
assign override[0] = (mode_of[0] != `TCOC_OM_OFF) &&
    (mode_of[0] != `TCOC_OM_TOGGLE || is_nonpwm || a_toggle_ok);
assign override[1] = (mode_of[1] != `TCOC_OM_OFF) &&
    (mode_of[1] != `TCOC_OM_TOGGLE || is_nonpwm);

// ****************************************************************
// Control register and read port
// ****************************************************************
always @(posedge clock)
begin
    if (!rst_b)
    begin
        timer_output_mode_control <= 6'h00;
        rdata <= `TCOC_CTRL_RESET;
    end
    else if (clk_en)
    begin
        if (reg_wr)
        begin
            // Strobe bits are not stored
            timer_output_mode_control <= {wdata[7:4], wdata[1:0]};
        end
        if (reg_rd)
        begin
            rdata <= read_value;
        end
        else
        begin
            rdata <= 8'h00;
        end
    end
end

// ****************************************************************
// Mode register
// ****************************************************************
always @(posedge clock)
begin
    if (!rst_b)
    begin
        waveform_mode_select <= 4'h0;
    end
    else if (clk_en)
    begin
        waveform_mode_select <= next_mode;
    end
end

// ****************************************************************
// Active compare values
// ****************************************************************
always @(posedge clock)
begin
    if (!rst_b)
    begin
        chan_a_compare_value <= 16'h0000;
        chan_b_compare_value <= 16'h0000;
    end
    else if (clk_en && timer_tick_enable && load_now)
    begin
        chan_a_compare_value <= chan_a_compare_buffer;
        chan_b_compare_value <= chan_b_compare_buffer;
    end
end

// ****************************************************************
// Pins and pin ownership
// ****************************************************************
always @(posedge clock)
begin
    if (!rst_b)
    begin
        chan_a_compare_pin <= 1'b0;
        chan_b_compare_pin <= 1'b0;
        chan_a_pin_override <= 1'b0;
        chan_b_pin_override <= 1'b0;
    end
    else if (clk_en)
    begin
        chan_a_compare_pin <= next_pin[0];
        chan_b_compare_pin <= next_pin[1];
        chan_a_pin_override <= override[0];
        chan_b_pin_override <= override[1];
    end
end

// ****************************************************************
// Match flags and counter clear
// ****************************************************************
always @(posedge clock)
begin
    if (!rst_b)
    begin
        chan_a_compare_match_flag <= 1'b0;
        chan_b_compare_match_flag <= 1'b0;
        match_clear_counter <= 1'b0;
    end
    else if (clk_en)
    begin
        // Set wins over clear; forced matches never reach flags
        if (timer_tick_enable && match_eq[0])
        begin
            chan_a_compare_match_flag <= 1'b1;
        end
        else if (flag_clear_a)
        begin
            chan_a_compare_match_flag <= 1'b0;
        end
        if (timer_tick_enable && match_eq[1])
        begin
            chan_b_compare_match_flag <= 1'b1;
        end
        else if (flag_clear_b)
        begin
            chan_b_compare_match_flag <= 1'b0;
        end
        match_clear_counter <= timer_tick_enable && match_eq[0] &&
            (wgm == 4'h4);
    end
end

endmodule // tcoc_compare_output
`default_nettype wire

// [src/tcoc_regs.vh]
/*
 Offsets, field positions, reset values and waveform mode codes
 for the timer compare-output control block.
 Assumes inclusion by bare name from the design file.
*/
`ifndef TCOC_REGS_VH
`define TCOC_REGS_VH
`define TCOC_IO_OFFSET 6'h2F
`define TCOC_DATA_OFFSET 8'h4F
`define TCOC_DATA_BIAS 8'h20
`define TCOC_CTRL_RESET 8'h00
`define TCOC_A_MODE_HI 7
`define TCOC_A_MODE_LO 6
`define TCOC_B_MODE_HI 5
`define TCOC_B_MODE_LO 4
`define TCOC_A_FORCE_BIT 3
`define TCOC_B_FORCE_BIT 2
`define TCOC_WGM_HI 1
`define TCOC_WGM_LO 0
`define TCOC_OM_OFF 2'h0
`define TCOC_OM_TOGGLE 2'h1
`define TCOC_OM_CLEAR 2'h2
`define TCOC_OM_SET 2'h3
`define TCOC_WGM_PFC_OCR 4'h9
`define TCOC_WGM_PC_ICR 4'hA
`define TCOC_WGM_FAST_ICR 4'hE
`define TCOC_WGM_FAST_OCR 4'hF
`define TCOC_WGM_RESERVED 4'hD
`define TCOC_BOTTOM 16'h0000
`endif

// [bench/tcoc_compare_output_asserts.sv]
/*
 Checker for the compare-output control block, channel A side.
 Assumes binding to the design top; sees only its ports.
*/
`default_nettype none
module tcoc_asserts (
    input wire logic clock,
    input wire logic rst_b,
    input wire logic clk_en,
    input wire logic timer_tick_enable,
    input wire logic [5:0] io_addr,
    input wire logic io_rd,
    input wire logic io_wr,
    input wire logic [7:0] wdata,
    input wire logic [1:0] waveform_mode_upper,
    input wire logic [7:0] rdata,
    input wire logic [3:0] waveform_mode_select,
    input wire logic chan_a_compare_pin,
    input wire logic chan_a_pin_override,
    input wire logic chan_a_compare_match_flag,
    input wire logic match_clear_counter
);
    timeunit 1ns;
    timeprecision 1ns;
    // ****************
    // Checks
    // ****************
    logic wr_hit;
    logic quiet_wr;
    assign wr_hit = clk_en && io_wr && io_addr == 6'h2F;
    assign quiet_wr = wr_hit && wdata[3] && !timer_tick_enable;
    default clocking cb @(posedge clock); endclocking
    default disable iff (!rst_b);
    sequence s_wr;
        wr_hit;
    endsequence
    sequence s_rd;
        clk_en && io_rd && io_addr == 6'h2F && !io_wr;
    endsequence
    sequence s_quiet_wr;
        quiet_wr;
    endsequence
    a_read_back: assert property (s_wr ##1 s_rd |=>
        rdata == ($past(wdata, 2) & 8'hF3)) else $error("read back");
    a_force_reads_zero: assert property (s_rd |=>
        rdata[3:2] == 2'h0) else $error("force bits read");
    a_pin_override: assert property (wr_hit && wdata[7:6] != 2'h1 |=>
        chan_a_pin_override == |($past(wdata) & 8'hC0)) else $error("ovr");
    a_force_action: assert property (quiet_wr && wdata[7] &&
        wdata[1:0] == 2'h0 && !waveform_mode_upper[1] &&
        waveform_mode_select[1:0] == 2'h0 && !waveform_mode_select[3] |=>
        chan_a_compare_pin == |($past(wdata) & 8'h40)) else $error("force");
    a_pwm_force_ignored: assert property (quiet_wr &&
        wdata[1:0] != 2'h0 &&
        waveform_mode_select == {waveform_mode_upper, wdata[1:0]} |=>
        $stable(chan_a_compare_pin)) else $error("pwm force");
    a_force_no_flag: assert property (s_quiet_wr |=>
        !$rose(chan_a_compare_match_flag) && !match_clear_counter)
        else $error("forced flag");
    a_flag_on_tick: assert property ($rose(chan_a_compare_match_flag)
        |-> $past(timer_tick_enable) && $past(clk_en)) else $error("flag");
    a_frozen_state: assert property (!clk_en |=>
        $stable(chan_a_compare_pin) && $stable(chan_a_compare_match_flag))
        else $error("frozen");
endmodule // tcoc_asserts
bind tcoc_compare_output tcoc_asserts u_chk (.*);
`default_nettype wire

// [bench/tcoc_compare_output_tb.sv]
/*
 Testbench for the compare-output control block.
 Assumes the design top and its bound checker are compiled first.
*/
`default_nettype none
module tcoc_compare_output_tb;
    timeunit 1ns;
    timeprecision 1ns;
    // ****************
    // Stimulus
    // ****************
    logic clock = 0, rst_b = 0, clk_en = 1, timer_tick_enable = 0;
    logic io_rd = 0, io_wr = 0, data_rd = 0, data_wr = 0, count_down = 0;
    logic flag_clear_a = 0, flag_clear_b = 0;
    logic [5:0] io_addr = 0;
    logic [7:0] data_addr = 0, wdata = 0, rdata;
    logic [1:0] waveform_mode_upper = 0;
    logic [15:0] counter_value = 0, counter_top = 16'h00FF;
    logic [15:0] chan_a_compare_buffer = 16'h0010;
    logic [15:0] chan_b_compare_buffer = 16'h0020;
    logic [15:0] chan_a_compare_value, chan_b_compare_value;
    logic [3:0] waveform_mode_select;
    logic chan_a_compare_pin, chan_b_compare_pin, match_clear_counter;
    logic chan_a_pin_override, chan_b_pin_override;
    logic chan_a_compare_match_flag, chan_b_compare_match_flag;
    int n_mismatch = 0, n_compared = 0, cycles = 0;
    tcoc_compare_output DUT (.*);
    always #25 clock = ~clock;
    task automatic chk(input string what, input logic [15:0] e, g);
        n_compared++;
        if (g !== e)
        begin
            n_mismatch++;
            $display("mismatch %s expected %h seen %h", what, e, g);
        end
    endtask
    task automatic wr(input logic io, input logic [7:0] d);
        io_addr = 6'h2F;
        data_addr = 8'h4F;
        wdata = d;
        io_wr = io;
        data_wr = !io;
        @(negedge clock);
        io_wr = 0;
        data_wr = 0;
    endtask
    task automatic rd(input logic io, input logic [7:0] e);
        io_addr = 6'h2F;
        data_addr = 8'h4F;
        io_rd = io;
        data_rd = !io;
        @(negedge clock);
        io_rd = 0;
        data_rd = 0;
        chk("ctrl read", e, rdata);
    endtask
    task automatic tick(input logic [15:0] v);
        counter_value = v;
        timer_tick_enable = 1;
        @(negedge clock);
        timer_tick_enable = 0;
        @(negedge clock);
    endtask
    task automatic t_reset;
        chk("pin a", 0, chan_a_compare_pin);
        rd(1, 8'h00);
        $display("done t_reset");
    endtask
    task automatic t_force;
        wr(1, 8'hC8);
        chk("pin a", 1, chan_a_compare_pin);
        chk("ovr a", 1, chan_a_pin_override);
        chk("clear cnt", 0, match_clear_counter);
        rd(1, 8'hC0);
        wr(1, 8'h88);
        chk("pin a", 0, chan_a_compare_pin);
        rd(1, 8'h80);
        wr(1, 8'h4C);
        chk("pin a", 1, chan_a_compare_pin);
        rd(1, 8'h40);
        wr(1, 8'h34);
        chk("pin b", 1, chan_b_compare_pin);
        chk("ovr a", 0, chan_a_pin_override);
        chk("ovr b", 1, chan_b_pin_override);
        chk("flag a", 0, chan_a_compare_match_flag);
        $display("done t_force");
    endtask
    task automatic t_pwm;
        wr(0, 8'hA1);
        rd(1, 8'hA1);
        wr(1, 8'hA9);
        chk("pin a", 1, chan_a_compare_pin);
        $display("done t_pwm");
    endtask
    task automatic t_match;
        wr(1, 8'h88);
        rd(1, 8'h80);
        wr(1, 8'hC0);
        chk("pin a", 0, chan_a_compare_pin);
        clk_en = 0;
        tick(16'h0010);
        chk("flag a", 0, chan_a_compare_match_flag);
        clk_en = 1;
        tick(16'h0005);
        chk("cmp a", 16'h0010, chan_a_compare_value);
        chk("cmp b", 16'h0020, chan_b_compare_value);
        tick(16'h0010);
        chk("flag a", 1, chan_a_compare_match_flag);
        chk("flag b", 0, chan_b_compare_match_flag);
        chk("pin a", 1, chan_a_compare_pin);
        $display("done t_match");
    endtask
    task automatic t_modes;
        waveform_mode_upper = 2'h3;
        wr(1, 8'h82);
        tick(16'h0010);
        chk("mode", 4'hE, waveform_mode_select);
        chk("pin a", 0, chan_a_compare_pin);
        tick(16'h0000);
        chk("pin a", 1, chan_a_compare_pin);
        waveform_mode_upper = 2'h2;
        tick(16'h0010);
        chk("pin a", 0, chan_a_compare_pin);
        count_down = 1;
        tick(16'h0010);
        chk("pin a", 1, chan_a_compare_pin);
        $display("done t_modes");
    endtask
    task automatic tally_and_finish;
        $display("compared %0d mismatched %0d", n_compared, n_mismatch);
        if (n_mismatch == 0 && n_compared > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask
    always @(posedge clock)
    begin
        cycles++;
        if (cycles == 600)
        begin
            n_mismatch++;
            tally_and_finish;
        end
    end
    initial
    begin
        repeat (3) @(negedge clock);
        rst_b = 1;
        t_reset;
        t_force;
        t_pwm;
        t_match;
        t_modes;
        tally_and_finish;
    end
endmodule // tcoc_compare_output_tb
`default_nettype wire
